// ---- rtl/jscr_router.v ----
// Scan chain and test clock router for one board of a stack
//
// Overview of operation
// RULE1: standalone: data through core, back out
// RULE2: stacked: data down, back up, then out
// RULE3: base-board sense selects the data path
// RULE4: setup mode inserts FPGAs and PLDs
// RULE5: no jumper means normal debug mode
// RULE6: setup select lights warning, reroutes path
// RULE7: sampling core returns clock to next device
// RULE8: debugger waits for return clock edge
// RULE9: return clock gated by request line
// RULE10: non-sampling core forwards test clock down
// RULE11: bottom board provides return clock path
// RULE12: base board drives return per request
// RULE13: PLD carries flash data in setup mode
// RULE14: debugger may raise halt request
// RULE15: acknowledge halt once core in debug
// RULE16: configured line released when setup complete
// RULE17: reset held until all FPGAs configured
// RULE18: routing is pure muxing, no register stages
`timescale 1ns/1ps
`include "jscr_defs.vh"

module jscr_router #(
  parameter CORE_SAMPLES_TCK = 0
) (
  // Clock and reset
  input  wire clk_i,
  input  wire sys_rst_i,
  // Debug connector
  input  wire tdi_i,
  input  wire tck_i,
  output wire tdo_o,
  output wire rtck_o,
  input  wire halt_request_i,
  output wire halt_acknowledge_o,
  // Strap and stack sense inputs
  input  wire base_board_sense_n_i,
  input  wire setup_select_n_i,
  // Processor core
  output wire core_tdi_o,
  input  wire core_tdo_i,
  output wire core_tck_o,
  input  wire core_rtck_i,
  output wire core_halt_request_o,
  input  wire core_in_debug_i,
  // Programmable devices (FPGA and PLD) chain segment
  output wire pld_tdi_o,
  input  wire pld_tdo_i,
  input  wire pld_flash_data_i,
  output wire flash_data_o,
  input  wire fpga_config_done_i,
  // Stack connector, downward
  output wire stack_tdi_o,
  output wire stack_tck_o,
  output wire clock_return_request_n_o,
  // Stack connector, upward return
  input  wire stack_tdo_i,
  input  wire stack_rtck_i,
  // Shared configured line, open collector
  input  wire config_done_line_i,
  output wire config_done_line_o,
  output wire config_done_line_oe_o,
  // Shared system reset line, open collector
  input  wire system_reset_line_n_i,
  output wire system_reset_line_n_o,
  output wire system_reset_line_n_oe_o,
  // Indicators and status
  output wire setup_warning_led_o,
  output reg  setup_mode_o,
  output reg  board_stacked_o,
  output reg  tck_rise_o
);

  // Number of flip-flops in each pin synchroniser
  localparam SYNC_W = `JSCR_SYNC_STAGES;

  // Test clock edge filter states
  localparam TCK_LOW  = 1'b0;
  localparam TCK_HIGH = 1'b1;

  // Pin synchronisers and their filtered levels
  reg  [SYNC_W-1:0] mb_sync_q;
  reg  [SYNC_W-1:0] cfg_sync_q;
  reg  [SYNC_W-1:0] tck_sync_q;
  reg               mb_q;
  reg               cfg_q;
  reg               tck_state_q;
  reg               tck_state_d;
  reg               tck_rise_d;
  wire              mb_agree;
  wire              cfg_agree;
  wire              tck_agree;

  // Combinational routing terms
  wire              stacked;
  wire              setup;
  wire              core_sampling;
  wire              core_out;
  reg               core_tdi_mux;
  reg               chain_out;
  reg               stack_tck_mux;
  reg               up_rtck;
  reg               flash_gate;
  reg               led_drive;

  // Active-low strap or sense pin reads as asserted
  function pin_active;
    input pin_n;
    begin
      pin_active = ~pin_n;
    end
  endfunction

  // Second and third synchroniser taps agree
  function taps_agree;
    input second_tap;
    input third_tap;
    begin
      taps_agree = (second_tap == third_tap);
    end
  endfunction

  // Two-way selector shared by data and clock steering
  function route_pick;
    input sel;
    input when_set;
    input when_clear;
    begin
      route_pick = sel ? when_set : when_clear;
    end
  endfunction

  // Path control straight from the pins, so the chain gains no stage
  assign stacked       = pin_active(base_board_sense_n_i); // RULE3
  assign setup         = pin_active(setup_select_n_i); // RULE5
  assign core_sampling = (CORE_SAMPLES_TCK != 0);

  // Data path into the core
  always @* begin
    core_tdi_mux = route_pick(stacked, stack_tdo_i, tdi_i); // RULE1 RULE2 RULE3 RULE18
  end

  assign core_tdi_o  = core_tdi_mux;
  assign core_out    = core_tdo_i;
  assign stack_tdi_o = tdi_i; // RULE2

  // Setup mode appends the programmable devices after the core
  assign pld_tdi_o = core_out; // RULE4

  always @* begin
    case (setup)
      1'b1: begin
        chain_out = pld_tdo_i; // RULE4 RULE6
      end
      default: begin
        chain_out = core_out; // RULE5
      end
    endcase
  end

  assign tdo_o = chain_out; // RULE1 RULE2 RULE18

  // Clock down the stack: a sampling core passes its return clock
  always @* begin
    if (core_sampling) begin
      stack_tck_mux = core_rtck_i; // RULE7
    end else begin
      stack_tck_mux = tck_i; // RULE10
    end
  end

  assign core_tck_o  = tck_i;
  assign stack_tck_o = stack_tck_mux;

  // Only a sampling core asks the base board for a return path
  assign clock_return_request_n_o = core_sampling ? 1'b0 : 1'b1; // RULE9

  // Return clock toward the connector
  always @* begin
    if (stacked) begin
      up_rtck = stack_rtck_i; // RULE9 RULE11 RULE12
    end else begin
      up_rtck = route_pick(core_sampling, core_rtck_i, tck_i); // RULE7
    end
  end

  assign rtck_o = up_rtck; // RULE7 RULE8

  // Halt request and acknowledge pass straight through
  assign core_halt_request_o = halt_request_i; // RULE14
  assign halt_acknowledge_o  = core_in_debug_i; // RULE15

  // Flash data moves only in setup mode
  always @* begin
    if (setup) begin
      flash_gate = pld_flash_data_i; // RULE13
    end else begin
      flash_gate = 1'b0;
    end
  end

  assign flash_data_o = flash_gate;

  // Warning indicator follows the setup strap on every board
  always @* begin
    led_drive = setup; // RULE6
  end

  assign setup_warning_led_o = led_drive;

  // Configured line: pulled low until the local FPGA is done
  assign config_done_line_o    = 1'b0;
  assign config_done_line_oe_o = ~fpga_config_done_i; // RULE16

  // Reset line: held low while any FPGA is still unconfigured
  assign system_reset_line_n_o    = 1'b0;
  assign system_reset_line_n_oe_o = ~config_done_line_i; // RULE17

  // Base-board sense synchroniser, idles high on its pull-up
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mb_sync_q <= {SYNC_W{1'b1}};
    end else begin
      mb_sync_q <= {mb_sync_q[SYNC_W-2:0], base_board_sense_n_i};
    end
  end

  // Setup strap synchroniser, idles high with no jumper
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_sync_q <= {SYNC_W{1'b1}};
    end else begin
      cfg_sync_q <= {cfg_sync_q[SYNC_W-2:0], setup_select_n_i};
    end
  end

  // Test clock synchroniser, idles low so reset gives no false edge
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tck_sync_q <= {SYNC_W{1'b0}};
    end else begin
      tck_sync_q <= {tck_sync_q[SYNC_W-2:0], tck_i};
    end
  end

  // A level counts once the last two taps agree
  assign mb_agree  = taps_agree(mb_sync_q[SYNC_W-2], mb_sync_q[SYNC_W-1]);
  assign cfg_agree = taps_agree(cfg_sync_q[SYNC_W-2], cfg_sync_q[SYNC_W-1]);
  assign tck_agree = taps_agree(tck_sync_q[SYNC_W-2], tck_sync_q[SYNC_W-1]);

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mb_q  <= 1'b1;
      cfg_q <= 1'b1;
    end else begin
      if (mb_agree) begin
        mb_q <= mb_sync_q[SYNC_W-1];
      end
      if (cfg_agree) begin
        cfg_q <= cfg_sync_q[SYNC_W-1];
      end
    end
  end

  // Test clock edge filter, one pulse per accepted rising edge
  always @* begin
    tck_state_d = tck_state_q;
    tck_rise_d  = 1'b0;
    case (tck_state_q)
      TCK_LOW: begin
        if (tck_agree && tck_sync_q[SYNC_W-1]) begin
          tck_state_d = TCK_HIGH;
          tck_rise_d  = 1'b1;
        end
      end
      TCK_HIGH: begin
        if (tck_agree && !tck_sync_q[SYNC_W-1]) begin
          tck_state_d = TCK_LOW;
        end
      end
      default: begin
        tck_state_d = TCK_LOW;
      end
    endcase
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tck_state_q <= TCK_LOW;
      tck_rise_o  <= 1'b0;
    end else begin
      tck_state_q <= tck_state_d;
      tck_rise_o  <= tck_rise_d;
    end
  end

  // Status copies for the board's own logic, not in the scan path
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      setup_mode_o    <= 1'b0;
      board_stacked_o <= 1'b0;
    end else begin
      setup_mode_o    <= pin_active(cfg_q); // RULE6
      board_stacked_o <= pin_active(mb_q); // RULE3
    end
  end

endmodule // jscr_router

// ---- common/jscr_defs.vh ----
// Constants for the scan chain router
`ifndef JSCR_DEFS_VH
`define JSCR_DEFS_VH
`define JSCR_SYNC_STAGES 3
`define JSCR_CLK_PERIOD_NS 10
`define JSCR_CFG_LATCH_CYC 2
`endif

// ---- verif/jscr_router_properties.sv ----
// Assertions on the scan chain router ports
`timescale 1ns/1ps
module jscr_router_properties (
  input wire clk_i, sys_rst_i, tdi_i, tck_i, core_tdo_i, pld_tdo_i, stack_tdo_i,
  input wire base_board_sense_n_i, setup_select_n_i, core_in_debug_i, fpga_config_done_i,
  input wire core_tdi_o, tdo_o, stack_tck_o, setup_warning_led_o, halt_acknowledge_o,
  input wire config_done_line_oe_o, setup_mode_o, board_stacked_o, tck_rise_o, rtck_o,
  input wire stack_rtck_i, pld_flash_data_i, flash_data_o, config_done_line_i,
  input wire system_reset_line_n_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence setup_held; !setup_select_n_i [*7]; endsequence
  sequence setup_off; setup_select_n_i [*7]; endsequence
  sequence base_held; !base_board_sense_n_i [*7]; endsequence
  a_solo_path: assert property (base_board_sense_n_i |-> core_tdi_o == tdi_i)
    else $error("solo path");
  a_stack_path: assert property (!base_board_sense_n_i |-> core_tdi_o == stack_tdo_i)
    else $error("stack path");
  a_normal_out: assert property (setup_select_n_i |-> tdo_o == core_tdo_i)
    else $error("normal out");
  a_setup_out: assert property (!setup_select_n_i |-> tdo_o == pld_tdo_i)
    else $error("setup out");
  a_led_mode: assert property (setup_warning_led_o == !setup_select_n_i)
    else $error("led");
  a_mode_sync: assert property (setup_held |-> setup_mode_o)
    else $error("mode sync");
  a_tck_fwd: assert property (stack_tck_o == tck_i)
    else $error("tck fwd");
  a_ack_follow: assert property (halt_acknowledge_o == core_in_debug_i)
    else $error("ack");
  a_done_release: assert property (config_done_line_oe_o == !fpga_config_done_i)
    else $error("done line");
  a_mode_clear: assert property (setup_off |-> !setup_mode_o)
    else $error("mode clear");
  a_stack_sync: assert property (base_held |-> board_stacked_o)
    else $error("stack sync");
  a_rise_single: assert property (tck_rise_o |=> !tck_rise_o)
    else $error("rise pulse");
  a_flash_off: assert property (setup_select_n_i |-> !flash_data_o)
    else $error("flash off");
  a_flash_pass: assert property (!setup_select_n_i |-> flash_data_o == pld_flash_data_i)
    else $error("flash pass");
  a_return_path: assert property (!base_board_sense_n_i |-> rtck_o == stack_rtck_i)
    else $error("return path");
  a_reset_hold: assert property (system_reset_line_n_oe_o == !config_done_line_i)
    else $error("reset hold");
endmodule // jscr_router_properties
bind jscr_router jscr_router_properties u_props (.*);

// ---- verif/jscr_base_model.sv ----
// Motherboard model at the bottom of the stack
`timescale 1ns/1ps
module jscr_base_model (
  input  wire stack_tdi_o, stack_tck_o, clock_return_request_n_o,
  output reg  stack_tdo_i = 1'b0,
  output wire stack_rtck_i
);
  always @(posedge stack_tck_o) stack_tdo_i <= stack_tdi_o;
  assign stack_rtck_i = ~clock_return_request_n_o & stack_tck_o;
endmodule // jscr_base_model

// ---- verif/jscr_router_tb_top.sv ----
// Random checks of the scan chain router
`timescale 1ns/1ps
module jscr_router_tb_top;
  reg clk_i = 0, sys_rst_i = 1, tdi_i = 0, tck_i = 0, halt_request_i = 0, core_tdo_i = 0;
  reg base_board_sense_n_i = 1, setup_select_n_i = 1, core_rtck_i = 0, core_in_debug_i = 0;
  reg pld_tdo_i = 0, pld_flash_data_i = 0, fpga_config_done_i = 0;
  wire tdo_o, rtck_o, halt_acknowledge_o, core_tdi_o, core_tck_o, core_halt_request_o;
  wire pld_tdi_o, flash_data_o, stack_tdi_o, stack_tck_o, clock_return_request_n_o;
  wire stack_tdo_i, stack_rtck_i, config_done_line_o, config_done_line_oe_o;
  wire system_reset_line_n_o, system_reset_line_n_oe_o, setup_warning_led_o;
  wire setup_mode_o, board_stacked_o, tck_rise_o;
  // Pull-ups on the shared lines
  wire config_done_line_i = ~config_done_line_oe_o;
  wire system_reset_line_n_i = ~system_reset_line_n_oe_o;
  integer errors = 0, checked = 0, seed = 94159, i;
  integer rises = 0, pulses = 0;
  reg [31:0] rnd;
  jscr_router u_jscr_router (.*);
  jscr_base_model u_jscr_base_model (.*);
  initial forever #5 clk_i = ~clk_i;
  // Debugger side: on a standalone board only, wait for the return clock before each edge
  initial #3 forever begin
    #40;
    wait (!base_board_sense_n_i || rtck_o === tck_i);
    tck_i = ~tck_i;
  end
  always @(posedge tck_i) rises = rises + 1;
  initial begin
    #200000;
    errors = errors + 1;
    test_done;
  end
  function pick(input s, a, b);
    pick = s ? a : b;
  endfunction
  task chk(input ok);
    checked = checked + 1;
    if (ok !== 1'b1) begin
      errors = errors + 1;
      $display("Error %0t mismatch", $time);
    end
  endtask
  task test_done;
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    sys_rst_i = 0;
    for (i = 0; i < 1000; i = i + 1) begin
      @(negedge clk_i);
      rnd = $random(seed);
      {tdi_i, halt_request_i, core_tdo_i, core_rtck_i, core_in_debug_i, pld_tdo_i,
       pld_flash_data_i, fpga_config_done_i} = rnd[7:0];
      // First four windows walk every sense and strap pair
      if (i % 8 == 0) {base_board_sense_n_i, setup_select_n_i} = (i < 32) ? i[4:3] : rnd[9:8];
      #1;
      chk(core_tdi_o === pick(base_board_sense_n_i, tdi_i, stack_tdo_i));
      chk(tdo_o === pick(setup_select_n_i, core_tdo_i, pld_tdo_i));
      chk(flash_data_o === (~setup_select_n_i & pld_flash_data_i));
      chk(rtck_o === pick(base_board_sense_n_i, tck_i, stack_rtck_i));
      chk(system_reset_line_n_oe_o === ~config_done_line_i);
      chk(core_halt_request_o === halt_request_i);
      chk(halt_acknowledge_o === core_in_debug_i);
      chk(pld_tdi_o === core_tdo_i);
      chk(stack_tdi_o === tdi_i);
      chk(core_tck_o === tck_i && stack_tck_o === tck_i);
      chk(clock_return_request_n_o === 1'b1);
      chk(setup_warning_led_o === ~setup_select_n_i);
      chk(config_done_line_oe_o === ~fpga_config_done_i);
      chk(config_done_line_o === 1'b0);
      chk(system_reset_line_n_o === 1'b0);
      pulses = pulses + tck_rise_o;
      if (i % 8 == 7) chk(board_stacked_o === ~base_board_sense_n_i);
      if (i % 8 == 7) chk(setup_mode_o === ~setup_select_n_i);
    end
    // A rise may still be in the synchroniser when the loop ends
    chk(rises - pulses >= 0 && rises - pulses <= 1);
    test_done;
  end
endmodule // jscr_router_tb_top
